/* File: spsr_regs.sv */
/*
  AXI4-Lite register bank for port 2 egress pacing, per-port default
  tags and per-port ingress policer drop counters, with the port 2
  queue pacers that use the rate settings.
  Assumes one clock, synchronous inputs, single-cycle drop pulses.
*/
// Chosen here: the AXI4-Lite register port.
// Contract
// [R1] Per-byte time of a queue is (field plus one) times 20 ns.
// [R2] First port 2 rate word: queue 1 in 25:13, queue 0 in 12:0.
// [R3] Second port 2 rate word: queue 3 upper field, queue 2 lower.
// [R4] Rates reset to zero; each queue paced by its time per byte.
// [R5] Default priority in bits 14:12, reset zero, used for egress tags.
// [R6] Default VLAN id in bits 11:0, reset zero, used for egress tags.
// [R7] Host, port 1 and port 2 tag registers at consecutive indices.
// [R8] Drop counter counts each packet dropped by ingress policing.
// [R9] Reading a drop counter returns its count and clears it.
// [R10] Drop counter saturates at all ones until read.
// [R11] One drop counter per source port, consecutive, reset zero.
// [R12] Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "spsr_defs.svh"

module spsr_regs
(
  input  wire  logic               I_SYS_CLK,
  input  wire  logic               I_RST,
  input  wire  logic               I_AWVALID,
  output var   logic               O_AWREADY,
  input  wire  logic [15:0]        I_AWADDR,
  input  wire  logic [2:0]         I_AWPROT,
  input  wire  logic               I_WVALID,
  output var   logic               O_WREADY,
  input  wire  logic [31:0]        I_WDATA,
  input  wire  logic [3:0]         I_WSTRB,
  output var   logic               O_BVALID,
  input  wire  logic               I_BREADY,
  output var   logic [1:0]         O_BRESP,
  input  wire  logic               I_ARVALID,
  output var   logic               O_ARREADY,
  input  wire  logic [15:0]        I_ARADDR,
  input  wire  logic [2:0]         I_ARPROT,
  output var   logic               O_RVALID,
  input  wire  logic               I_RREADY,
  output var   logic [31:0]        O_RDATA,
  output var   logic [1:0]         O_RRESP,
  input  wire  logic [2:0]         I_DROP,
  input  wire  logic [3:0]         I_Q_SENT,
  output var   logic [3:0]         O_Q_READY,
  output var   spsr_pkg::spsr_rates_t O_Q_RATE,
  output var   spsr_pkg::spsr_tags_t  O_DEF_TAG
);
  import spsr_pkg::*;

  spsr_state_t s_r;
  spsr_state_t s_nxt;
  logic [13:0] wr_idx;
  logic [13:0] rd_idx;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic        rd_take;
  logic [2:0]  rd_clr;

  // Byte-lane merge of the pending write
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = {8{s_r.wstrb[b]}};
    end
  end

  assign wr_idx  = s_r.awaddr[15:2];
  assign rd_idx  = I_ARADDR[15:2];
  assign rd_take = s_r.arready && I_ARVALID;

  // Next state of bus, registers, counters and pacers
  always_comb
  begin
    s_nxt  = s_r;
    wval   = 32'h0000_0000;
    rd_clr = 3'h0;

    // Write address and data taken in either order
    if (s_r.awready && I_AWVALID)
    begin
      s_nxt.aw_ok  = 1'b1;
      s_nxt.awaddr = I_AWADDR;
    end
    if (s_r.wready && I_WVALID)
    begin
      s_nxt.w_ok  = 1'b1;
      s_nxt.wdata = I_WDATA;
      s_nxt.wstrb = I_WSTRB;
    end

    // Commit the write once both halves are held
    if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid)
    begin
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `SPSR_RESP_OKAY;
      unique case (wr_idx)
        `SPSR_IDX_P2_Q01_RATE:
        begin
          wval = ({6'h00, s_r.rate[1], s_r.rate[0]} & ~wmask)
               | (s_r.wdata & wmask);
          wval = wval & `SPSR_RATE_MASK; // see [R12]
          s_nxt.rate[1] = wval[`SPSR_RATE_HI_MSB:`SPSR_RATE_HI_LSB]; // see [R2]
          s_nxt.rate[0] = wval[`SPSR_RATE_LO_MSB:`SPSR_RATE_LO_LSB]; // see [R2]
        end
        `SPSR_IDX_P2_Q23_RATE:
        begin
          wval = ({6'h00, s_r.rate[3], s_r.rate[2]} & ~wmask)
               | (s_r.wdata & wmask);
          wval = wval & `SPSR_RATE_MASK; // see [R12]
          s_nxt.rate[3] = wval[`SPSR_RATE_HI_MSB:`SPSR_RATE_HI_LSB]; // see [R3]
          s_nxt.rate[2] = wval[`SPSR_RATE_LO_MSB:`SPSR_RATE_LO_LSB]; // see [R3]
        end
        `SPSR_IDX_HOST_TAG, `SPSR_IDX_P1_TAG, `SPSR_IDX_P2_TAG:
        begin
          for (int p = 0; p < 3; p++)
          begin
            if (wr_idx == `SPSR_IDX_HOST_TAG + 14'(p)) // see [R7]
            begin
              wval = ({17'h0_0000, s_r.tag[p]} & ~wmask)
                   | (s_r.wdata & wmask);
              wval = wval & `SPSR_TAG_MASK; // see [R12]
              s_nxt.tag[p].prio =
                wval[`SPSR_PRIO_MSB:`SPSR_PRIO_LSB]; // see [R5]
              s_nxt.tag[p].vid  =
                wval[`SPSR_VID_MSB:`SPSR_VID_LSB]; // see [R6]
            end
          end
        end
        `SPSR_IDX_HOST_DROPS, `SPSR_IDX_P1_DROPS, `SPSR_IDX_P2_DROPS:
        begin
          s_nxt.bresp = `SPSR_RESP_OKAY; // Counters ignore writes
        end
        default:
        begin
          s_nxt.bresp = `SPSR_RESP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && I_BREADY)
    begin
      s_nxt.bvalid = 1'b0;
    end
    s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_ok && !s_nxt.bvalid;

    // Read: data latched at the address handshake
    if (rd_take)
    begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = `SPSR_RESP_OKAY;
      s_nxt.rdata   = 32'h0000_0000; // see [R12]
      unique case (rd_idx)
        `SPSR_IDX_P2_Q01_RATE:
          s_nxt.rdata = {6'h00, s_r.rate[1], s_r.rate[0]}; // see [R2]
        `SPSR_IDX_P2_Q23_RATE:
          s_nxt.rdata = {6'h00, s_r.rate[3], s_r.rate[2]}; // see [R3]
        `SPSR_IDX_HOST_TAG:
          s_nxt.rdata = {17'h0_0000, s_r.tag[0]}; // see [R5] [R6]
        `SPSR_IDX_P1_TAG:
          s_nxt.rdata = {17'h0_0000, s_r.tag[1]}; // see [R7]
        `SPSR_IDX_P2_TAG:
          s_nxt.rdata = {17'h0_0000, s_r.tag[2]}; // see [R7]
        `SPSR_IDX_HOST_DROPS:
        begin
          s_nxt.rdata = s_r.drops[0];
          rd_clr[0]   = 1'b1; // see [R9]
        end
        `SPSR_IDX_P1_DROPS:
        begin
          s_nxt.rdata = s_r.drops[1];
          rd_clr[1]   = 1'b1; // see [R11]
        end
        `SPSR_IDX_P2_DROPS:
        begin
          s_nxt.rdata = s_r.drops[2];
          rd_clr[2]   = 1'b1; // see [R11]
        end
        default:
          s_nxt.rresp = `SPSR_RESP_SLVERR;
      endcase
    end
    if (s_r.rvalid && I_RREADY)
    begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
    if (!s_r.rvalid && !s_r.arready && !rd_take)
    begin
      s_nxt.arready = 1'b1; // Ready after reset
    end

    // Drop counters: a drop in the clearing cycle is kept
    for (int p = 0; p < 3; p++)
    begin
      if (rd_clr[p])
      begin
        s_nxt.drops[p] = `SPSR_CNT_RST
                       + {31'h0000_0000, I_DROP[p]}; // see [R9]
      end
      else if (I_DROP[p] && s_r.drops[p] != `SPSR_CNT_MAX) // see [R10]
      begin
        s_nxt.drops[p] = s_r.drops[p] + 32'h0000_0001; // see [R8]
      end
    end

    // Queue pacers: hold off for (rate + 1) * unit after each byte
    for (int q = 0; q < 4; q++)
    begin
      if (I_Q_SENT[q])
      begin
        s_nxt.wait_ns[q] = 18'({5'h00, s_r.rate[q]} + 18'h0_0001)
                         * `SPSR_UNIT_NS; // see [R1] [R4]
      end
      else if (s_r.wait_ns[q] > `SPSR_CLK_NS)
      begin
        s_nxt.wait_ns[q] = s_r.wait_ns[q] - `SPSR_CLK_NS;
      end
      else
      begin
        s_nxt.wait_ns[q] = 18'h0_0000;
      end
      s_nxt.q_ready[q] = (s_nxt.wait_ns[q] == 18'h0_0000); // see [R4]
    end
  end

  // State register; all fields clear, which is every reset value
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      s_r <= '0; // see [R4] [R11]
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign O_AWREADY = s_r.awready;
  assign O_WREADY  = s_r.wready;
  assign O_BVALID  = s_r.bvalid;
  assign O_BRESP   = s_r.bresp;
  assign O_ARREADY = s_r.arready;
  assign O_RVALID  = s_r.rvalid;
  assign O_RDATA   = s_r.rdata;
  assign O_RRESP   = s_r.rresp;
  assign O_Q_READY = s_r.q_ready;
  assign O_Q_RATE  = s_r.rate;
  assign O_DEF_TAG = s_r.tag;

  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  property p_r1;
    I_Q_SENT[0] |=> s_r.wait_ns[0] ==
      18'(({5'h00, $past(s_r.rate[0])} + 18'h0_0001) * 18'd20);
  endproperty
  a_r1: assert property (p_r1) // see [R1]
    else $error("pacing load wrong");

  property p_r2;
    rd_take && rd_idx == `SPSR_IDX_P2_Q01_RATE |=>
      O_RDATA == {6'h00, $past(s_r.rate[1]), $past(s_r.rate[0])};
  endproperty
  a_r2: assert property (p_r2) // see [R2]
    else $error("queue 0/1 rate read wrong");

  property p_r3;
    rd_take && rd_idx == `SPSR_IDX_P2_Q23_RATE |=>
      O_RDATA[25:13] == $past(O_Q_RATE[3]) &&
      O_RDATA[12:0] == $past(O_Q_RATE[2]);
  endproperty
  a_r3: assert property (p_r3) // see [R3]
    else $error("queue 2/3 rate read wrong");

  property p_r4;
    I_Q_SENT[0] && s_r.rate[0] == 13'h0000 ##1 (!I_Q_SENT[0])[*3] |=>
      O_Q_READY[0] && !$past(O_Q_READY[0]);
  endproperty
  a_r4: assert property (p_r4) // see [R4]
    else $error("queue not ready after pacing time");

  property p_r5;
    rd_take && rd_idx == `SPSR_IDX_HOST_TAG |=>
      O_RDATA[14:12] == $past(O_DEF_TAG[0].prio) && O_RDATA[31:15] == 17'h0;
  endproperty
  a_r5: assert property (p_r5) // see [R5]
    else $error("default priority read wrong");

  property p_r6;
    rd_take && rd_idx == `SPSR_IDX_P2_TAG |=>
      O_RDATA[11:0] == $past(O_DEF_TAG[2].vid);
  endproperty
  a_r6: assert property (p_r6) // see [R6]
    else $error("default vlan id read wrong");

  property p_r8;
    I_DROP[1] && !rd_clr[1] && s_r.drops[1] != `SPSR_CNT_MAX |=>
      s_r.drops[1] == $past(s_r.drops[1]) + 32'h0000_0001;
  endproperty
  a_r8: assert property (p_r8) // see [R8]
    else $error("drop not counted");

  property p_r9;
    rd_clr[0] |=> O_RDATA == $past(s_r.drops[0]) &&
      s_r.drops[0] == {31'h0, $past(I_DROP[0])};
  endproperty
  a_r9: assert property (p_r9) // see [R9]
    else $error("read did not clear counter");

  property p_r10;
    s_r.drops[2] == `SPSR_CNT_MAX && !rd_clr[2] |=>
      s_r.drops[2] == `SPSR_CNT_MAX;
  endproperty
  a_r10: assert property (p_r10) // see [R10]
    else $error("counter left saturation");

  property p_r11;
    $past(I_RST) |-> s_r.drops == '0 && O_Q_RATE == '0;
  endproperty
  a_r11: assert property (p_r11) // see [R11]
    else $error("reset value wrong");

  property p_r12;
    rd_take && rd_idx >= `SPSR_IDX_P2_Q01_RATE && rd_idx <= `SPSR_IDX_P2_TAG
      |=> O_RDATA[31:26] == 6'h00 &&
      ($past(rd_idx) < `SPSR_IDX_HOST_TAG || O_RDATA[31:15] == 17'h0);
  endproperty
  a_r12: assert property (p_r12) // see [R12]
    else $error("reserved bits not zero");

  c_write: cover property (s_r.bvalid && I_BREADY);
  c_read_clr: cover property (rd_clr[0] && I_DROP[0]);
  c_sat: cover property (s_r.drops[2] == `SPSR_CNT_MAX);
  c_pace: cover property ($rose(O_Q_READY[3]));

endmodule : spsr_regs
`default_nettype wire

/* File: spsr_defs.svh */
/*
  Offsets, field positions, reset values and timing figures of the
  port shaping, default tag and drop counter register bank.
  Assumes word addressing: byte address is four times the index.
*/
`ifndef SPSR_DEFS_SVH
`define SPSR_DEFS_SVH

// Register indices
`define SPSR_IDX_P2_Q01_RATE  14'h1C11
`define SPSR_IDX_P2_Q23_RATE  14'h1C12
`define SPSR_IDX_HOST_TAG     14'h1C13
`define SPSR_IDX_P1_TAG       14'h1C14
`define SPSR_IDX_P2_TAG       14'h1C15
`define SPSR_IDX_HOST_DROPS   14'h1C16
`define SPSR_IDX_P1_DROPS     14'h1C17
`define SPSR_IDX_P2_DROPS     14'h1C18

// Field positions
`define SPSR_RATE_HI_MSB      25
`define SPSR_RATE_HI_LSB      13
`define SPSR_RATE_LO_MSB      12
`define SPSR_RATE_LO_LSB      0
`define SPSR_PRIO_MSB         14
`define SPSR_PRIO_LSB         12
`define SPSR_VID_MSB          11
`define SPSR_VID_LSB          0

// Writable bit masks
`define SPSR_RATE_MASK        32'h03FF_FFFF
`define SPSR_TAG_MASK         32'h0000_7FFF

// Reset values
`define SPSR_RATE_RST         13'h0000
`define SPSR_PRIO_RST         3'h0
`define SPSR_VID_RST          12'h000
`define SPSR_CNT_RST          32'h0000_0000
`define SPSR_CNT_MAX          32'hFFFF_FFFF

// Timing: pacing unit and clock period in ns
`define SPSR_UNIT_NS          18'h0_0014
`define SPSR_CLK_NS           18'h0_0008

// Bus answers
`define SPSR_RESP_OKAY        2'h0
`define SPSR_RESP_SLVERR      2'h2

`endif

/* File: spsr_pkg.sv */
/*
  Types of the port shaping register bank.
  Assumes spsr_defs.svh is on the include path.
*/
package spsr_pkg;

  // Default tag of one port
  typedef struct packed {
    logic [2:0]  prio;
    logic [11:0] vid;
  } spsr_tag_t;

  typedef spsr_tag_t [2:0] spsr_tags_t;
  typedef logic [3:0][12:0] spsr_rates_t;

  // Whole state of the bank
  typedef struct packed {
    spsr_rates_t       rate;
    spsr_tags_t        tag;
    logic [2:0][31:0]  drops;
    logic [3:0][17:0]  wait_ns;
    logic [3:0]        q_ready;
    logic              aw_ok;
    logic              w_ok;
    logic [15:0]       awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } spsr_state_t;

endpackage : spsr_pkg

/* File: spsr_fabric_model.sv */
/*
  Behavioural switch fabric side: policer drop pulses, byte sends.
  Assumes the bank samples both at the rising edge of i_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module spsr_fabric_model
(
  input  wire logic       i_clk,
  input  wire logic [3:0] i_q_ready,
  output var  logic [2:0] o_drop,
  output var  logic [3:0] o_q_sent
);

  // Idle fabric
  initial
  begin
    o_drop   = 3'h0;
    o_q_sent = 4'h0;
  end

  // Drop n packets on the ports in mask, held high one per clock
  task automatic drop(input logic [2:0] mask, input int n);
    @(posedge i_clk);
    o_drop <= mask;
    repeat (n) @(posedge i_clk);
    o_drop <= 3'h0;
  endtask : drop

  // Start one byte on queue q; n counts the cycles the pacer holds it
  task automatic send(input int q, output int n);
    @(posedge i_clk);
    o_q_sent[q] <= 1'b1;
    @(posedge i_clk);
    o_q_sent[q] <= 1'b0;
    n = 0;
    @(negedge i_clk);
    while (!i_q_ready[q] && n < 30000)
    begin
      n++;
      @(negedge i_clk);
    end
  endtask : send

endmodule : spsr_fabric_model
`default_nettype wire

/* File: switch_port_shaping_regs_bench.sv */
/*
  Self-checking bench of the shaping, tag and drop counter bank.
  Assumes spsr_pkg compiled and spsr_defs.svh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spsr_defs.svh"

module switch_port_shaping_regs_bench;
  import spsr_pkg::*;

  localparam logic [15:0] rate_base = {`SPSR_IDX_P2_Q01_RATE, 2'b00};
  localparam logic [15:0] tag_base  = {`SPSR_IDX_HOST_TAG, 2'b00};
  localparam logic [15:0] drop_base = {`SPSR_IDX_HOST_DROPS, 2'b00};

  logic        clk;
  logic        rst;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic [15:0] awaddr;
  logic [15:0] araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic [2:0]  drop;
  logic [3:0]  sent;
  logic [3:0]  q_ready;
  spsr_rates_t q_rate;
  spsr_tags_t  def_tag;
  logic [12:0] rate_exp [4] = '{13'h0000, 13'h1FFF, 13'h0001, 13'h0005};
  int          mismatches;
  int          n_checks;

  spsr_regs u_spsr_regs
  (
    .I_SYS_CLK(clk), .I_RST(rst),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
    .I_AWPROT(3'h0), .I_WVALID(wvalid), .O_WREADY(wready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid),
    .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .I_ARADDR(araddr), .I_ARPROT(3'h0),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata),
    .O_RRESP(rresp), .I_DROP(drop), .I_Q_SENT(sent),
    .O_Q_READY(q_ready), .O_Q_RATE(q_rate), .O_DEF_TAG(def_tag)
  );

  spsr_fabric_model u_spsr_fabric_model
  (
    .i_clk(clk), .i_q_ready(q_ready), .o_drop(drop), .o_q_sent(sent)
  );

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts and reports one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    do
    begin
      @(posedge clk);
      if (awready && awvalid)
        awvalid <= 1'b0;
      if (wready && wvalid)
        wvalid <= 1'b0;
    end
    while (awvalid || wvalid);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : wr

  // AXI4-Lite read, judged against expected data and response
  task automatic rd(input logic [15:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask : rd

  // Every register reads zero after reset
  task automatic t_reset;
    chk(32'(q_ready), 32'h0000_000F);
    chk(32'(def_tag == '0), 32'h0000_0001);
    for (int i = 0; i < 8; i++)
      rd(rate_base + 16'(4 * i), 32'h0, `SPSR_RESP_OKAY);
  endtask : t_reset

  // Rate fields, their reserved bits and the shaper outputs
  task automatic t_rates;
    wr(rate_base, 32'hFFFF_FFFF, `SPSR_RESP_OKAY);
    rd(rate_base, `SPSR_RATE_MASK, `SPSR_RESP_OKAY);
    wr(rate_base, 32'hFFFF_E000, `SPSR_RESP_OKAY);
    wr(rate_base + 16'h4, 32'h0000_A001, `SPSR_RESP_OKAY);
    rd(rate_base, 32'h03FF_E000, `SPSR_RESP_OKAY);
    rd(rate_base + 16'h4, 32'h0000_A001, `SPSR_RESP_OKAY);
    for (int q = 0; q < 4; q++)
      chk(32'(q_rate[q]), 32'(rate_exp[q]));
  endtask : t_rates

  // Each queue held off for its per-byte time, rounded up to clocks
  task automatic t_pace;
    int n;
    int e;
    for (int q = 0; q < 4; q++)
    begin
      u_spsr_fabric_model.send(q, n);
      e = ((int'(rate_exp[q]) + 1) * 20 + 7) / 8;
      chk(32'(n), 32'(e));
    end
  endtask : t_pace

  // Three default tags at consecutive places, reserved bits dropped
  task automatic t_tags;
    logic [31:0] d;
    for (int p = 0; p < 3; p++)
      wr(tag_base + 16'(4 * p), 32'h8765_4321 + 32'(p) * 32'h1111,
         `SPSR_RESP_OKAY);
    for (int p = 0; p < 3; p++)
    begin
      d = (32'h8765_4321 + 32'(p) * 32'h1111) & `SPSR_TAG_MASK;
      rd(tag_base + 16'(4 * p), d, `SPSR_RESP_OKAY);
      chk(32'(def_tag[p]), d);
    end
    // Only byte lane 1 replaced; the other lanes keep their value
    wstrb <= 4'h2;
    wr(tag_base, 32'h0000_7F00, `SPSR_RESP_OKAY);
    wstrb <= 4'hF;
    rd(tag_base, 32'h0000_7F21, `SPSR_RESP_OKAY);
  endtask : t_tags

  // Per-port drop counts, write ignored, cleared by reading
  task automatic t_drops;
    u_spsr_fabric_model.drop(3'b001, 5);
    u_spsr_fabric_model.drop(3'b110, 3);
    u_spsr_fabric_model.drop(3'b100, 2);
    wr(drop_base, 32'h1234_5678, `SPSR_RESP_OKAY);
    rd(drop_base, 32'h5, `SPSR_RESP_OKAY);
    rd(drop_base + 16'h4, 32'h3, `SPSR_RESP_OKAY);
    rd(drop_base + 16'h8, 32'h5, `SPSR_RESP_OKAY);
    for (int i = 0; i < 3; i++)
      rd(drop_base + 16'(4 * i), 32'h0, `SPSR_RESP_OKAY);
  endtask : t_drops

  // Neighbouring unmapped words refused, nothing stored
  task automatic t_unmapped;
    rd(16'h7040, 32'h0, `SPSR_RESP_SLVERR);
    wr(16'h7040, 32'hFFFF_FFFF, `SPSR_RESP_SLVERR);
    rd(16'h7064, 32'h0, `SPSR_RESP_SLVERR);
    rd(rate_base, 32'h03FF_E000, `SPSR_RESP_OKAY);
  endtask : t_unmapped

  // Verdict and end of run
  task automatic test_done;
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 64'h0;
    wstrb = 4'hF;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_rates();
    t_pace();
    t_tags();
    t_drops();
    t_unmapped();
    test_done();
  end

  // Watchdog well beyond the longest pacing wait
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    test_done();
  end

endmodule : switch_port_shaping_regs_bench
`default_nettype wire
